/* File: sms_pkg.sv */
// Shared constants and types for the SPI port and its link partner
package sms_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_STATUS = 32'hffff0a00;
    localparam logic [31:0] ADDR_RX = 32'hffff0a04;
    localparam logic [31:0] ADDR_TX = 32'hffff0a08;
    localparam logic [31:0] ADDR_DIV = 32'hffff0a0c;
    localparam logic [31:0] ADDR_CTRL = 32'hffff0a10;

    // ------------------------------------------------------------
    // Control fields and reset values
    // ------------------------------------------------------------
    localparam int CTL_EN = 0;
    localparam int CTL_MASTER = 1;
    localparam int CTL_CPOL = 2;
    localparam int CTL_CPHA = 3;
    localparam int CTL_TMDE = 6;
    localparam int CTL_RFLH = 12;
    localparam int CTL_TFLH = 13;
    localparam int CTL_THR_LO = 14;
    localparam int CTL_W = 16;
    localparam int DIV_W = 6;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [5:0] DIV_RST = 6'h00;

    // ------------------------------------------------------------
    // Transfer geometry
    // ------------------------------------------------------------
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int PTR_W = 2;
    localparam int CNT_W = 3;
    localparam logic [3:0] LAST_EDGE = 4'hf;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int MASTER_MAX_BPS = 20_000_000;
    localparam int SLAVE_MAX_BPS = 10_000_000;
    // Least divider keeping generated clock at or under master limit
    localparam int MIN_DIV = (CLK_HZ + 2 * MASTER_MAX_BPS - 1) / (2 * MASTER_MAX_BPS) - 1;
    // Least half period, in clocks, that a far master may use
    localparam int MIN_HALF = (CLK_HZ + 2 * SLAVE_MAX_BPS - 1) / (2 * SLAVE_MAX_BPS);

    typedef enum logic [2:0] {
        SM_IDLE = 3'b000,
        SM_SETUP = 3'b001,
        SM_XFER = 3'b010,
        SM_HOLD = 3'b011,
        SM_GAP = 3'b100
    } sms_state_t;

endpackage : sms_pkg

/* File: sms_link_if.sv */
// Four-wire serial link between the port and its partner
`timescale 1ns/1ps
interface sms_link_if;
    logic devSclkO, devSclkOe, devMosiO, devMosiOe;
    logic devMisoO, devMisoOe, devSsnO, devSsnOe;
    logic prtSclkO, prtSclkOe, prtMosiO, prtMosiOe;
    logic prtMisoO, prtMisoOe, prtSsnO, prtSsnOe;
    logic sclk, mosi, miso, ssN;

    // Undriven wires float to the pull-up level
    assign sclk = devSclkOe ? devSclkO : (prtSclkOe ? prtSclkO : 1'b1);
    assign mosi = devMosiOe ? devMosiO : (prtMosiOe ? prtMosiO : 1'b1);
    assign miso = devMisoOe ? devMisoO : (prtMisoOe ? prtMisoO : 1'b1);
    assign ssN = devSsnOe ? devSsnO : (prtSsnOe ? prtSsnO : 1'b1);

    modport dev (
        output devSclkO, devSclkOe, devMosiO, devMosiOe,
        output devMisoO, devMisoOe, devSsnO, devSsnOe,
        input sclk, mosi, miso, ssN
    );
    modport prt (
        output prtSclkO, prtSclkOe, prtMosiO, prtMosiOe,
        output prtMisoO, prtMisoOe, prtSsnO, prtSsnOe,
        input sclk, mosi, miso, ssN
    );
endinterface : sms_link_if

/* File: sms_port.sv */
// Serial port with four-byte FIFOs, master or slave, APB registers
// How it works
// - Bytes, MSB first, full duplex
// - Pin directions follow master or slave
// - One byte per eight clock periods
// - Master clock is core over 2(1+div), div floored at 1
// - Polarity and phase come from control
// - Launch one edge, sample the other
// - Slave to 10 Mbps, master to 20
// - Slave select input frames the bytes
// - Master drives select low per transfer
// - Far master holds select low throughout
// - Bit 11: receive count above threshold
// - Bits 10:8 give receive fill level
// - Bit 7: overflow, sticky, read clears
// - Bit 6: receive count reached, read clears
// - Bit 5: transmit count reached, read clears
// - Bit 4: underflow on empty start
// - Bits 3:1 give transmit fill level
// - Bit 0: any interrupt but underflow under transmit flush, read clears
// - Receive reads pop, transmit writes push
// - Control 15:14 picks one to four bytes
// - Divider register is six bits
// - Receive flush drops bytes, no interrupts but underflow
// - Transmit flush ignores transmit writes
`timescale 1ns/1ps
module sms_port import sms_pkg::*; (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial link
    sms_link_if.dev link
);
    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    logic [CTL_W-1:0] ctrlReg;
    logic [DIV_W-1:0] divReg;
    wire apbAcc = psel & penable & ce;
    wire hitStatus = (paddr == ADDR_STATUS);
    wire hitRx = (paddr == ADDR_RX);
    wire hitTx = (paddr == ADDR_TX);
    wire hitDiv = (paddr == ADDR_DIV);
    wire hitCtrl = (paddr == ADDR_CTRL);
    wire mapped = hitStatus | hitRx | hitTx | hitDiv | hitCtrl;
    wire wrAcc = apbAcc & pwrite & mapped;
    wire rdAcc = apbAcc & ~pwrite & mapped;
    wire statusRead = rdAcc & hitStatus;

    wire en = ctrlReg[CTL_EN];
    wire isMaster = ctrlReg[CTL_MASTER];
    wire cpol = ctrlReg[CTL_CPOL];
    wire cpha = ctrlReg[CTL_CPHA];
    wire tmde = ctrlReg[CTL_TMDE];
    wire rxFlush = ctrlReg[CTL_RFLH];
    wire txFlush = ctrlReg[CTL_TFLH];
    wire [CNT_W-1:0] need = {1'b0, ctrlReg[CTL_THR_LO+1:CTL_THR_LO]} + 3'h1;
    wire masterOn = en & isMaster;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrlReg <= CTRL_RST;
            divReg <= DIV_RST;
        end else if (wrAcc & hitCtrl) begin
            ctrlReg <= pwdata[CTL_W-1:0];
        end else if (wrAcc & hitDiv) begin
            divReg <= pwdata[DIV_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // FIFOs
    // ------------------------------------------------------------
    logic [BYTE_W-1:0] txMem [FIFO_DEPTH];
    logic [BYTE_W-1:0] rxMem [FIFO_DEPTH];
    logic [PTR_W-1:0] txRd, txWr, rxRd, rxWr;
    logic [CNT_W-1:0] txCnt, rxCnt;
    logic loadByte, byteDone;
    logic [BYTE_W-1:0] rxByte;

    wire txFull = (txCnt == CNT_W'(FIFO_DEPTH));
    wire rxFull = (rxCnt == CNT_W'(FIFO_DEPTH));
    wire txPush = wrAcc & hitTx & ~txFlush & ~txFull;
    wire txPop = loadByte & (txCnt != '0);
    wire rxPush = byteDone & ~rxFlush & ~rxFull;
    wire rxPop = rdAcc & hitRx & (rxCnt != '0);
    wire [BYTE_W-1:0] txHead = (txCnt != '0) ? txMem[txRd] : 8'h00;

    for (genvar i = 0; i < FIFO_DEPTH; i++) begin : g_entry
        // Cleared so a read of an empty queue after reset shows zero
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                txMem[i] <= '0;
                rxMem[i] <= '0;
            end else if (ce) begin
                if (txPush && txWr == PTR_W'(i)) begin
                    txMem[i] <= pwdata[BYTE_W-1:0];
                end
                if (rxPush && rxWr == PTR_W'(i)) begin
                    rxMem[i] <= rxByte;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txRd <= '0;
            txWr <= '0;
            txCnt <= '0;
            rxRd <= '0;
            rxWr <= '0;
            rxCnt <= '0;
        end else if (ce) begin
            txRd <= txFlush ? txWr : txRd + PTR_W'(txPop);
            txWr <= txWr + PTR_W'(txPush);
            txCnt <= txFlush ? '0 : txCnt + CNT_W'(txPush) - CNT_W'(txPop);
            rxRd <= rxFlush ? rxWr : rxRd + PTR_W'(rxPop);
            rxWr <= rxWr + PTR_W'(rxPush);
            rxCnt <= rxFlush ? '0 : rxCnt + CNT_W'(rxPush) - CNT_W'(rxPop);
        end
    end

    // ------------------------------------------------------------
    // Master clock generator and sequencer
    // ------------------------------------------------------------
    // Divider below the floor would exceed the master bit-rate limit
    wire [DIV_W-1:0] effDiv = (divReg < DIV_W'(MIN_DIV)) ? DIV_W'(MIN_DIV) : divReg;
    sms_state_t mState, mNext;
    logic [DIV_W:0] halfCnt;
    logic sclkReg, ssReg, loadM;
    logic [3:0] edgeCnt;
    wire tick = (halfCnt == {1'b0, effDiv});
    wire gapTick = (halfCnt == {effDiv, 1'b1});
    wire lastEdge = (edgeCnt == LAST_EDGE);

    always_comb begin
        mNext = mState;
        loadM = 1'b0;
        case (mState)
            SM_IDLE: begin
                if (masterOn && txCnt != '0) begin
                    mNext = SM_SETUP;
                    loadM = 1'b1;
                end
            end
            SM_SETUP: if (tick) mNext = SM_XFER;
            SM_XFER: if (tick && lastEdge) mNext = SM_HOLD;
            SM_HOLD: if (tick) mNext = SM_GAP;
            SM_GAP: if (gapTick) mNext = SM_IDLE; // one clock period stall
            default: mNext = SM_IDLE;
        endcase
        if (!masterOn) begin
            mNext = SM_IDLE;
        end
    end

    wire selLow = (mNext == SM_SETUP) | (mNext == SM_XFER) | (mNext == SM_HOLD);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mState <= SM_IDLE;
            halfCnt <= '0;
            sclkReg <= 1'b0;
            ssReg <= 1'b1;
        end else if (ce) begin
            mState <= mNext;
            halfCnt <= (mState != mNext || (tick && mState == SM_XFER)) ? '0 : halfCnt + 7'h1;
            sclkReg <= (mState == SM_XFER) ? (sclkReg ^ tick) : cpol;
            ssReg <= ~selLow;
        end
    end

    // ------------------------------------------------------------
    // Shared edge engine
    // ------------------------------------------------------------
    logic sclkPrev, ssPrev, outBit;
    logic [BYTE_W-1:0] txSh, rxSh;
    wire slaveOn = en & ~isMaster;
    wire slaveSel = slaveOn & ~link.ssN;
    wire slaveEdge = slaveSel & (link.sclk != sclkPrev);
    wire slaveLead = (sclkPrev == cpol);
    wire anyEdge = isMaster ? ((mState == SM_XFER) & tick) : slaveEdge;
    wire leadEdge = isMaster ? (sclkReg == cpol) : slaveLead;
    wire sampleNow = anyEdge & (leadEdge ^ cpha);
    wire launchNow = anyEdge & ~(leadEdge ^ cpha) & ~lastEdge;
    wire inBit = isMaster ? link.miso : link.mosi;
    wire ssFall = slaveSel & ssPrev;
    assign byteDone = anyEdge & lastEdge;
    assign loadByte = loadM | (slaveOn & (ssFall | (byteDone & ~link.ssN)));
    assign rxByte = cpha ? {rxSh[BYTE_W-2:0], inBit} : rxSh;
    wire frameIdle = isMaster ? (mState != SM_XFER && mState != SM_SETUP) : ~slaveSel;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclkPrev <= 1'b0;
            ssPrev <= 1'b1;
            edgeCnt <= '0;
        end else if (ce) begin
            sclkPrev <= link.sclk;
            ssPrev <= link.ssN;
            edgeCnt <= frameIdle ? '0 : edgeCnt + 4'(anyEdge);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            outBit <= 1'b0;
            txSh <= '0;
            rxSh <= '0;
        end else if (ce) begin
            if (loadByte) begin
                outBit <= cpha ? outBit : txHead[BYTE_W-1];
                txSh <= cpha ? txHead : {txHead[BYTE_W-2:0], 1'b0};
            end else if (launchNow) begin
                outBit <= txSh[BYTE_W-1];
                txSh <= {txSh[BYTE_W-2:0], 1'b0};
            end
            if (sampleNow) begin
                rxSh <= {rxSh[BYTE_W-2:0], inBit};
            end
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    logic fofReg, rxIrqReg, txIrqReg, txUfReg, anyReg;
    logic [CNT_W-1:0] sentCnt;
    wire sentHit = byteDone & tmde & (sentCnt + 3'h1 == need);
    wire fofSet = byteDone & ~rxFlush & rxFull;
    wire rxIrqSet = rxPush & ~tmde & (rxCnt + 3'h1 >= need);
    wire txIrqSet = sentHit & ~rxFlush;
    wire txUfSet = loadByte & (txCnt == '0);
    wire anySet = fofSet | rxIrqSet | txIrqSet | (txUfSet & ~txFlush);
    wire rexBit = (rxCnt > need);
    wire keep = ~statusRead;
    wire [31:0] statusWord = {20'h0, rexBit, rxCnt, fofReg, rxIrqReg, txIrqReg,
                              txUfReg, txCnt, anyReg};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fofReg <= 1'b0;
            rxIrqReg <= 1'b0;
            txIrqReg <= 1'b0;
            txUfReg <= 1'b0;
            anyReg <= 1'b0;
            sentCnt <= '0;
        end else if (ce) begin
            fofReg <= fofSet | (fofReg & keep);
            rxIrqReg <= rxIrqSet | (rxIrqReg & keep);
            txIrqReg <= txIrqSet | (txIrqReg & keep);
            txUfReg <= txUfSet | (txUfReg & keep);
            anyReg <= anySet | (anyReg & keep);
            if (!tmde || sentHit) begin
                sentCnt <= '0;
            end else if (byteDone) begin
                sentCnt <= sentCnt + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Bus answer and pins
    // ------------------------------------------------------------
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = hitStatus ? statusWord :
                    hitRx ? {24'h0, rxMem[rxRd]} :
                    hitDiv ? {26'h0, divReg} :
                    hitCtrl ? {16'h0, ctrlReg} : 32'h0;

    // Idle level straight from control: no stray edge when enable and polarity land together
    assign link.devSclkO = (mState == SM_XFER) ? sclkReg : cpol;
    assign link.devSclkOe = masterOn;
    assign link.devMosiO = outBit;
    assign link.devMosiOe = masterOn;
    assign link.devSsnO = ssReg;
    assign link.devSsnOe = masterOn;
    assign link.devMisoO = outBit;
    assign link.devMisoOe = slaveSel;

endmodule : sms_port

/* File: sms_partner.sv */
// Far end of the link: plain master or slave with a byte stream port
`timescale 1ns/1ps
module sms_partner import sms_pkg::*; #(
    parameter int HALF = MIN_HALF
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Role and clock shape
    input wire logic asMaster,
    input wire logic cpol,
    input wire logic cpha,
    // Byte stream
    input wire logic [7:0] txData,
    input wire logic txValid,
    output logic txReady,
    output logic [7:0] rxData,
    output logic rxValid,
    output logic busy,
    // Serial link
    sms_link_if.prt link
);
    // ------------------------------------------------------------
    // Master sequencer
    // ------------------------------------------------------------
    sms_state_t pState, pNext;
    logic [7:0] halfCnt;
    logic sclkReg, ssReg, loadM;
    logic [3:0] edgeCnt;
    // Half period never shorter than the device slave accepts
    wire tick = (halfCnt == 8'(((HALF < MIN_HALF) ? MIN_HALF : HALF) - 1));
    wire lastEdge = (edgeCnt == LAST_EDGE);
    wire mEdge = (pState == SM_XFER) & tick;
    logic byteDone;

    always_comb begin
        pNext = pState;
        loadM = 1'b0;
        case (pState)
            SM_IDLE: begin
                if (asMaster && txValid) begin
                    pNext = SM_SETUP;
                    loadM = 1'b1;
                end
            end
            SM_SETUP: if (tick) pNext = SM_XFER;
            SM_XFER: begin
                if (tick && lastEdge) begin
                    loadM = txValid;
                    pNext = txValid ? SM_SETUP : SM_HOLD;
                end
            end
            SM_HOLD: if (tick) pNext = SM_IDLE;
            default: pNext = SM_IDLE;
        endcase
        if (!asMaster) begin
            pNext = SM_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pState <= SM_IDLE;
            halfCnt <= '0;
            sclkReg <= 1'b0;
            ssReg <= 1'b1;
        end else if (ce) begin
            pState <= pNext;
            halfCnt <= (pState != pNext || tick) ? '0 : halfCnt + 8'h1;
            sclkReg <= (pState == SM_XFER) ? (sclkReg ^ tick) : cpol;
            ssReg <= (pNext == SM_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Edge engine
    // ------------------------------------------------------------
    logic sclkPrev, ssPrev, outBit, pend;
    logic [7:0] txSh, rxSh;
    wire slaveSel = ~asMaster & ~link.ssN;
    wire anyEdge = asMaster ? mEdge : (slaveSel & (link.sclk != sclkPrev));
    wire leadEdge = asMaster ? (sclkReg == cpol) : (sclkPrev == cpol);
    wire sampleNow = anyEdge & (leadEdge ^ cpha);
    wire launchNow = anyEdge & ~(leadEdge ^ cpha) & ~lastEdge;
    wire inBit = asMaster ? link.miso : link.mosi;
    assign byteDone = anyEdge & lastEdge;
    // A byte taken at byte end is kept for the next frame, not reloaded at select fall
    wire loadByte = loadM | (slaveSel & ((ssPrev & ~pend) | byteDone));
    wire [7:0] loadVal = txValid ? txData : 8'h00;
    wire frameIdle = asMaster ? (pState != SM_XFER && pState != SM_SETUP) : ~slaveSel;
    assign txReady = loadByte & txValid;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclkPrev <= 1'b0;
            ssPrev <= 1'b1;
            edgeCnt <= '0;
            outBit <= 1'b0;
            txSh <= '0;
            rxSh <= '0;
            rxData <= '0;
            rxValid <= 1'b0;
            pend <= 1'b0;
        end else if (ce) begin
            pend <= ~asMaster & (byteDone | (pend & ~(slaveSel & ssPrev)));
            sclkPrev <= link.sclk;
            ssPrev <= link.ssN;
            edgeCnt <= (frameIdle || byteDone) ? '0 : edgeCnt + 4'(anyEdge);
            if (loadByte) begin
                outBit <= cpha ? outBit : loadVal[7];
                txSh <= cpha ? loadVal : {loadVal[6:0], 1'b0};
            end else if (launchNow) begin
                outBit <= txSh[7];
                txSh <= {txSh[6:0], 1'b0};
            end
            if (sampleNow) begin
                rxSh <= {rxSh[6:0], inBit};
            end
            rxValid <= byteDone;
            if (byteDone) begin
                rxData <= cpha ? {rxSh[6:0], inBit} : rxSh;
            end
        end
    end

    assign busy = asMaster ? (pState != SM_IDLE) : slaveSel;
    assign link.prtSclkO = sclkReg;
    assign link.prtSclkOe = asMaster;
    assign link.prtMosiO = outBit;
    assign link.prtMosiOe = asMaster;
    assign link.prtSsnO = ssReg;
    assign link.prtSsnOe = asMaster;
    assign link.prtMisoO = outBit;
    assign link.prtMisoOe = slaveSel;

endmodule : sms_partner

/* File: sms_port_props.sv */
// Link properties watched between the port and its partner
`timescale 1ns/1ps
module sms_port_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Link
    input wire logic devSclkOe,
    input wire logic devMosiOe,
    input wire logic devMisoOe,
    input wire logic devSsnOe,
    input wire logic prtSsnOe,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic ssN
);
    // ------------------------------------------------
    // Edge count inside a select frame
    // ------------------------------------------------
    logic sclkQ;
    logic [6:0] edgeCnt;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclkQ <= 1'b0;
            edgeCnt <= 7'h00;
        end else begin
            sclkQ <= sclk;
            edgeCnt <= ssN ? 7'h00 : edgeCnt + 7'(sclk != sclkQ);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_master_pins: assert property (devSclkOe |-> devMosiOe && devSsnOe && !devMisoOe)
        else $error("master pin directions wrong");
    chk_slave_pins: assert property (devMisoOe |-> !devSclkOe && !devSsnOe && !devMosiOe)
        else $error("slave pin directions wrong");
    chk_miso_release: assert property (!devSsnOe && ssN && $past(ssN) |-> !devMisoOe)
        else $error("miso driven while deselected");
    chk_frame_edges: assert property (devSsnOe && $rose(ssN) |-> edgeCnt == 7'h10)
        else $error("master frame edge count wrong");
    chk_frame_close: assert property (devSsnOe && $fell(ssN) |-> (!ssN)[*8] ##[1:1000] ssN)
        else $error("master select frame length wrong");
    chk_idle_clock: assert property (devSclkOe && $past(devSclkOe) && ssN && $past(ssN)
        |-> $stable(sclk)) else $error("clock moved outside frame");
    chk_half_min: assert property (devSclkOe && !ssN && $changed(sclk) |=> $stable(sclk))
        else $error("master clock too fast");
    chk_launch_edge: assert property (devMosiOe && !ssN && !$past(ssN) && $changed(mosi)
        |-> $changed(sclk)) else $error("data moved off clock edge");
    chk_far_frame: assert property (prtSsnOe && $rose(ssN)
        |-> edgeCnt != 7'h00 && edgeCnt[3:0] == 4'h0) else $error("far frame broke a byte");
    cover property (devSsnOe && $rose(ssN));
    cover property (prtSsnOe && $rose(ssN));
    cover property (devMisoOe && $changed(sclk));
endmodule : sms_port_props

/* File: tb.sv */
// Self-checking bench: port and partner joined over the link
`timescale 1ns/1ps
module tb import sms_pkg::*;;
    logic clk, rstn, psel, penable, pwrite, pslverr, pready, rdErr;
    logic [31:0] paddr, pwdata, prdata, rdData;
    logic asM, cpol, cpha, ptValid, ptReady, prValid, sclkQ;
    logic [7:0] ptData, prData;
    logic [1:0] pol;
    logic [7:0] pTx[$], pRx[$], dTx[$];
    integer seed = 72302;
    int nMismatch = 0, nChecks = 0, lim, d, halfRun, halfSeen;
    sms_link_if link ();
    sms_port sms_port_i (.clk(clk), .rstn(rstn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link.dev));
    sms_partner sms_partner_i (.clk(clk), .rstn(rstn), .ce(1'b1), .asMaster(asM), .cpol(cpol),
        .cpha(cpha), .txData(ptData), .txValid(ptValid), .txReady(ptReady), .rxData(prData),
        .rxValid(prValid), .busy(), .link(link.prt));
    sms_port_props sms_port_props_i (.clk(clk), .rstn(rstn), .devSclkOe(link.devSclkOe),
        .devMosiOe(link.devMosiOe), .devMisoOe(link.devMisoOe), .devSsnOe(link.devSsnOe),
        .prtSsnOe(link.prtSsnOe), .sclk(link.sclk), .mosi(link.mosi), .ssN(link.ssN));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Far-end byte feed, capture and half-period meter
    always @(posedge clk) begin
        if (ptReady === 1'b1) pTx.push_back(ptData);
        // Offered byte holds while valid until taken
        if (ptReady === 1'b1 || ptValid !== 1'b1) ptData <= 8'($random(seed));
        ptValid <= (pTx.size() < lim);
        if (prValid === 1'b1) pRx.push_back(prData);
        sclkQ <= link.sclk;
        halfRun <= (link.sclk !== sclkQ) ? 1 : halfRun + 1;
        if (link.sclk !== sclkQ && link.devSclkOe && !link.ssN) halfSeen <= halfRun;
    end
    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    task automatic complete_run();
        if (nMismatch == 0 && nChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        nChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (pready !== 1'b1) begin
            nMismatch++;
            complete_run();
        end
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rdData);
    endtask : rdc
    // Waits for n captured bytes and a closed frame; bounded
    task automatic waitRx(input int n);
        int i;
        for (i = 0; i < 30000 && !(pRx.size() >= n && link.ssN === 1'b1); i++) @(posedge clk);
        if (i == 30000) begin
            nMismatch++;
            complete_run();
        end
        @(posedge clk);
    endtask : waitRx
    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        rstn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {asM, cpol, cpha} = '0;
        lim = 0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        rdc(ADDR_STATUS, 32'h0, "status");
        rdc(ADDR_RX, 32'h0, "rxByte");
        rdc(32'hffff0a14, 32'h0, "unmapped");
        chk("slverr", 32'h1, {31'h0, rdErr});
        apb(1'b1, ADDR_DIV, 32'hff);
        rdc(ADDR_DIV, 32'h3f, "divMax");
        // Master run; the fifth push meets a full queue
        for (int k = 0; k < 5; k++) begin
            dTx.push_back(8'($random(seed)));
            apb(1'b1, ADDR_TX, {24'h0, dTx[k]});
        end
        rdc(ADDR_STATUS, 32'h8, "txLevel");
        d = $unsigned($random(seed)) % 4;
        pol = 2'($random(seed));
        cpol <= pol[0];
        cpha <= pol[1];
        lim = 4;
        apb(1'b1, ADDR_DIV, 32'(d));
        apb(1'b1, ADDR_CTRL, {16'h0, 12'h404, pol, 2'b11});
        waitRx(4);
        chk("halfPeriod", 32'(d < 2 ? 2 : d + 1), 32'(halfSeen));
        rdc(ADDR_STATUS, 32'hc21, "statusMaster");
        rdc(ADDR_STATUS, 32'hc00, "statusCleared");
        for (int k = 0; k < 4; k++) begin
            rdc(ADDR_RX, {24'h0, pTx[k]}, "devRx");
            chk("farRx", {24'h0, dTx[k]}, {24'h0, pRx[k]});
        end
        rdc(ADDR_STATUS, 32'h0, "drained");
        chk("farCount", 32'h4, 32'(pRx.size()));
        // Slave run: two bytes queued, five arrive
        apb(1'b1, ADDR_CTRL, 32'h0);
        lim = 0;
        pTx.delete();
        pRx.delete();
        dTx.delete();
        asM <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            dTx.push_back(8'($random(seed)));
            apb(1'b1, ADDR_TX, {24'h0, dTx[k]});
        end
        apb(1'b1, ADDR_CTRL, {28'h0, pol, 2'b01});
        lim = 5;
        waitRx(5);
        rdc(ADDR_STATUS, 32'hcd1, "statusSlave");
        for (int k = 0; k < 5; k++) begin
            chk("farRxSlave", {24'h0, (k < 2) ? dTx[k] : 8'h00}, {24'h0, pRx[k]});
        end
        for (int k = 0; k < 4; k++) begin
            rdc(ADDR_RX, {24'h0, pTx[k]}, "devRxSlave");
        end
        // Both flushes on: pushes and arrivals are dropped
        apb(1'b1, ADDR_CTRL, {16'h0, 12'h300, pol, 2'b01});
        apb(1'b1, ADDR_TX, 32'h5a);
        rdc(ADDR_STATUS, 32'h0, "flushIdle");
        pTx.delete();
        pRx.delete();
        lim = 1;
        waitRx(1);
        rdc(ADDR_STATUS, 32'h10, "flushStatus");
        chk("flushTx", 32'h0, {24'h0, pRx[0]});
        complete_run();
    end
endmodule : tb
